//--- verilog/thcb_pkg.sv
// Package for the threshold and hysteresis configuration bank.
// Assumes one 40 MHz clock and a host reaching the bank over the two-wire serial bus.
package thcb_pkg;

  localparam logic [7:0] OFS_A_NEAR   = 8'h60;
  localparam logic [7:0] OFS_A_CONT   = 8'h61;
  localparam logic [7:0] OFS_A_FIRM   = 8'h63;
  localparam logic [7:0] OFS_SETTINGS = 8'h80;
  localparam logic [7:0] OFS_81       = 8'h81;
  localparam logic [7:0] OFS_82       = 8'h82;
  localparam logic [7:0] OFS_83       = 8'h83;

  localparam int TOUCH_CODE_LSB = 4;
  localparam int NEAR_CODE_LSB  = 0;
  localparam logic [7:0] SETTINGS_RSVD_MASK = 8'hCC;

  localparam logic [7:0] RST_SETTINGS = 8'hA2;
  localparam logic [7:0] RST_81       = 8'h0A;
  localparam logic [7:0] RST_82       = 8'h16;
  localparam logic [7:0] RST_83       = 8'h25;
  localparam logic [7:0] RST_A_THR    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Bus address of the device; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {
    MARGIN_OFF     = 2'h0,
    MARGIN_EIGHTH  = 2'h1,
    MARGIN_QUARTER = 2'h2,
    MARGIN_SIXTEEN = 2'h3
  } thcb_margin_t;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_HOST_ACK
  } thcb_state_t;

  typedef struct packed {
    logic [7:0]  hyst_near;
    logic [7:0]  hyst_near_margin;
    logic [9:0]  hyst_contact;
    logic [9:0]  hyst_contact_margin;
    logic        halt_always;
    logic [7:0]  halt_thr;
    logic [7:0]  a_near;
    logic [15:0] a_contact;
    logic [15:0] a_firm;
    logic [7:0]  b_near;
    logic [7:0]  b_contact;
    logic [9:0]  b_firm;
  } thcb_thr_t;

endpackage

//--- verilog/thcb_bank.sv
// Threshold and hysteresis configuration bank with its two-wire serial slave.
// Assumes the serial pins are open drain with pull-ups, and the baselines come from
// logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module thcb_bank (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic               dual_sar_mode,
  input  wire logic [15:0]        long_term_baseline_a,
  output thcb_pkg::thcb_thr_t     thr
);

  // Storage for the seven mapped offsets
  logic [7:0] sar_ant1_near_threshold;
  logic [7:0] sar_ant1_contact_threshold;
  logic [7:0] sar_ant1_firm_contact_threshold;
  logic [7:0] margin_ui_settings;
  logic [7:0] margin_ui_filter_halt_threshold;
  logic [7:0] margin_ui_near_threshold;
  logic [7:0] margin_ui_contact_threshold;

  logic [2:0]            scl_sync;
  logic [2:0]            sda_sync;
  logic                  scl_f;
  logic                  sda_f;
  logic                  scl_prev;
  logic                  sda_prev;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_cond;
  logic                  stop_cond;
  thcb_pkg::thcb_state_t state;
  logic [3:0]            bit_cnt;
  logic [7:0]            shreg;
  logic [7:0]            ptr;
  logic                  rw;
  logic                  wr_fire;
  logic [7:0]            rd_data;
  logic [1:0]            touch_code;
  logic [1:0]            near_code;
  logic [1:0]            near_sel;

  function automatic logic [9:0] margin_of(input logic [9:0] t, input logic [1:0] code);
    unique case (code)
      thcb_pkg::MARGIN_OFF:     margin_of = 10'h000;
      thcb_pkg::MARGIN_EIGHTH:  margin_of = {3'h0, t[9:3]};
      thcb_pkg::MARGIN_QUARTER: margin_of = {2'h0, t[9:2]};
      thcb_pkg::MARGIN_SIXTEEN: margin_of = {4'h0, t[9:4]};
    endcase
  endfunction

  function automatic logic [15:0] baseline_scale(input logic [7:0] v, input logic [15:0] long_term_baseline);
    logic [23:0] prod;
    prod = {16'h0000, v} * {8'h00, long_term_baseline};
    baseline_scale = prod[23:8];
  endfunction

  // Three-stage pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  assign scl_rise   = scl_f && !scl_prev;
  assign scl_fall   = !scl_f && scl_prev;
  assign start_cond = scl_f && scl_prev && sda_prev && !sda_f;
  assign stop_cond  = scl_f && scl_prev && !sda_prev && sda_f;
  assign wr_fire    = scl_fall && (state == thcb_pkg::ST_WDATA) && (bit_cnt == thcb_pkg::BITS_PER_BYTE);

  // Read mux; in dual-pad mode the margin fields read back as zero
  always_comb begin
    rd_data = thcb_pkg::UNMAPPED_READ;
    unique case (ptr)
      thcb_pkg::OFS_A_NEAR:   rd_data = sar_ant1_near_threshold;
      thcb_pkg::OFS_A_CONT:   rd_data = sar_ant1_contact_threshold;
      thcb_pkg::OFS_A_FIRM:   rd_data = sar_ant1_firm_contact_threshold;
      thcb_pkg::OFS_SETTINGS: rd_data = dual_sar_mode ? 8'h00 : margin_ui_settings;
      thcb_pkg::OFS_81:       rd_data = margin_ui_filter_halt_threshold;
      thcb_pkg::OFS_82:       rd_data = margin_ui_near_threshold;
      thcb_pkg::OFS_83:       rd_data = margin_ui_contact_threshold;
      default:                rd_data = thcb_pkg::UNMAPPED_READ;
    endcase
  end

  // Serial slave: shift on the rising clock, change outputs on the falling clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state   <= thcb_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
    end else if (start_cond) begin
      state   <= thcb_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
    end else if (stop_cond) begin
      state <= thcb_pkg::ST_IDLE;
    end else if (scl_rise) begin
      unique case (state)
        thcb_pkg::ST_ADDR, thcb_pkg::ST_REG, thcb_pkg::ST_WDATA: begin
          shreg   <= {shreg[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end
        thcb_pkg::ST_RDATA: bit_cnt <= bit_cnt + 4'h1;
        thcb_pkg::ST_HOST_ACK: begin
          if (sda_f) begin
            state <= thcb_pkg::ST_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state)
        thcb_pkg::ST_ADDR: begin
          if (bit_cnt == thcb_pkg::BITS_PER_BYTE) begin
            if (shreg[7:1] == thcb_pkg::DEV_ADDR) begin
              state <= thcb_pkg::ST_ADDR_ACK;
              rw    <= shreg[0];
            end else begin
              state <= thcb_pkg::ST_IDLE;
            end
          end
        end
        thcb_pkg::ST_ADDR_ACK: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            state <= thcb_pkg::ST_RDATA;
            shreg <= rd_data;
            ptr   <= ptr + 8'h01;
          end else begin
            state <= thcb_pkg::ST_REG;
          end
        end
        thcb_pkg::ST_REG: begin
          if (bit_cnt == thcb_pkg::BITS_PER_BYTE) begin
            ptr   <= shreg;
            state <= thcb_pkg::ST_REG_ACK;
          end
        end
        thcb_pkg::ST_WDATA: begin
          if (bit_cnt == thcb_pkg::BITS_PER_BYTE) begin
            ptr   <= ptr + 8'h01;
            state <= thcb_pkg::ST_WDATA_ACK;
          end
        end
        thcb_pkg::ST_REG_ACK, thcb_pkg::ST_WDATA_ACK: begin
          bit_cnt <= 4'h0;
          state   <= thcb_pkg::ST_WDATA;
        end
        thcb_pkg::ST_RDATA: begin
          if (bit_cnt == thcb_pkg::BITS_PER_BYTE) begin
            state <= thcb_pkg::ST_HOST_ACK;
          end else begin
            shreg <= {shreg[6:0], 1'b0};
          end
        end
        thcb_pkg::ST_HOST_ACK: begin
          bit_cnt <= 4'h0;
          state   <= thcb_pkg::ST_RDATA;
          shreg   <= rd_data;
          ptr     <= ptr + 8'h01;
        end
        default: ;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = (state == thcb_pkg::ST_ADDR_ACK) || (state == thcb_pkg::ST_REG_ACK) ||
                   (state == thcb_pkg::ST_WDATA_ACK) || ((state == thcb_pkg::ST_RDATA) && !shreg[7]);

  // Register writes; one storage per offset, shared by both modes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sar_ant1_near_threshold         <= thcb_pkg::RST_A_THR;
      sar_ant1_contact_threshold      <= thcb_pkg::RST_A_THR;
      sar_ant1_firm_contact_threshold <= thcb_pkg::RST_A_THR;
      margin_ui_settings              <= thcb_pkg::RST_SETTINGS;
      margin_ui_filter_halt_threshold <= thcb_pkg::RST_81;
      margin_ui_near_threshold        <= thcb_pkg::RST_82;
      margin_ui_contact_threshold     <= thcb_pkg::RST_83;
    end else if (wr_fire) begin
      unique case (ptr)
        thcb_pkg::OFS_A_NEAR: sar_ant1_near_threshold <= shreg;
        thcb_pkg::OFS_A_CONT: sar_ant1_contact_threshold <= shreg;
        thcb_pkg::OFS_A_FIRM: sar_ant1_firm_contact_threshold <= shreg;
        // Reserved bits keep their reset pattern; margin fields are fixed in dual-pad mode
        thcb_pkg::OFS_SETTINGS: begin
          if (!dual_sar_mode) begin
            margin_ui_settings <= (thcb_pkg::RST_SETTINGS & thcb_pkg::SETTINGS_RSVD_MASK) |
                                  (shreg & ~thcb_pkg::SETTINGS_RSVD_MASK);
          end
        end
        thcb_pkg::OFS_81: margin_ui_filter_halt_threshold <= shreg;
        thcb_pkg::OFS_82: margin_ui_near_threshold <= shreg;
        thcb_pkg::OFS_83: margin_ui_contact_threshold <= shreg;
        default: ;
      endcase
    end
  end

  assign touch_code = dual_sar_mode ? 2'h0 : margin_ui_settings[thcb_pkg::TOUCH_CODE_LSB +: 2];
  assign near_code  = dual_sar_mode ? 2'h0 : margin_ui_settings[thcb_pkg::NEAR_CODE_LSB +: 2];
  // Near code 10 is a second one-eighth code, unlike the touch field
  assign near_sel   = (near_code == 2'h2) ? 2'h1 : near_code;

  // Effective thresholds; registered so the pipeline sees glitch-free values.
  // The inactive mode's view is zeroed so a consumer cannot misread shared offsets.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      thr <= '0;
    end else begin
      thr.a_near    <= sar_ant1_near_threshold;
      thr.a_contact <= baseline_scale(sar_ant1_contact_threshold, long_term_baseline_a);
      thr.a_firm    <= baseline_scale(sar_ant1_firm_contact_threshold, long_term_baseline_a);
      if (dual_sar_mode) begin
        thr.hyst_near           <= 8'h00;
        thr.hyst_near_margin    <= 8'h00;
        thr.hyst_contact        <= 10'h000;
        thr.hyst_contact_margin <= 10'h000;
        thr.halt_always         <= 1'b0;
        thr.halt_thr            <= 8'h00;
        thr.b_near              <= margin_ui_filter_halt_threshold;
        thr.b_contact           <= margin_ui_near_threshold;
        thr.b_firm              <= {margin_ui_contact_threshold, 2'h0};
      end else begin
        thr.hyst_near           <= margin_ui_near_threshold;
        thr.hyst_near_margin    <= 8'(margin_of({2'h0, margin_ui_near_threshold}, near_sel));
        thr.hyst_contact        <= {margin_ui_contact_threshold, 2'h0};
        thr.hyst_contact_margin <= margin_of({margin_ui_contact_threshold, 2'h0}, touch_code);
        thr.halt_always         <= (margin_ui_filter_halt_threshold == 8'h00);
        thr.halt_thr            <= margin_ui_filter_halt_threshold;
        thr.b_near              <= 8'h00;
        thr.b_contact           <= 8'h00;
        thr.b_firm              <= 10'h000;
      end
    end
  end

  a_touch_eighth: assert property (@(posedge mclk) disable iff (!rst_n)
    (!dual_sar_mode && touch_code == 2'h1) |=>
      thr.hyst_contact_margin == {3'h0, $past(margin_ui_contact_threshold), 2'h0} >> 3)
    else $error("touch margin not one eighth");

  a_touch_sixteenth: assert property (@(posedge mclk) disable iff (!rst_n)
    (!dual_sar_mode && touch_code == 2'h3) |=>
      thr.hyst_contact_margin == {4'h0, $past(margin_ui_contact_threshold[7:2])})
    else $error("touch margin not one sixteenth");

  a_near_margin_code: assert property (@(posedge mclk) disable iff (!rst_n)
    (!dual_sar_mode && near_code[1] != near_code[0]) |=>
      thr.hyst_near_margin == {3'h0, $past(margin_ui_near_threshold[7:3])})
    else $error("near margin codes 01/10 not one eighth");

  a_halt_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 (!$past(dual_sar_mode)) |-> (thr.halt_always == ($past(margin_ui_filter_halt_threshold) == 8'h00)))
    else $error("halt-always flag wrong");

  a_contact_times4: assert property (@(posedge mclk) disable iff (!rst_n)
    !dual_sar_mode |=> thr.hyst_contact == 10'($past(margin_ui_contact_threshold) * 4))
    else $error("contact threshold not times four");

  a_dual_no_margin: assert property (@(posedge mclk) disable iff (!rst_n)
    dual_sar_mode [*2] |-> thr.hyst_contact_margin == 10'h000 && thr.hyst_near_margin == 8'h00)
    else $error("margin active in dual-pad mode");

  a_pad_a_scale: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 1'b1 |-> thr.a_contact ==
      16'(({16'h0000, $past(sar_ant1_contact_threshold)} * {8'h00, $past(long_term_baseline_a)}) >> 8))
    else $error("pad A contact scaling wrong");

  a_pad_b_firm: assert property (@(posedge mclk) disable iff (!rst_n)
    dual_sar_mode |=> thr.b_firm == {$past(margin_ui_contact_threshold), 2'h0} &&
      thr.b_near == $past(margin_ui_filter_halt_threshold))
    else $error("pad B thresholds wrong");

  a_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_fire && ptr == thcb_pkg::OFS_82) |=> margin_ui_near_threshold == $past(shreg) ##1
      (dual_sar_mode || thr.hyst_near == $past(margin_ui_near_threshold)))
    else $error("write to 0x82 not applied");

  a_near_plain: assert property (@(posedge mclk) disable iff (!rst_n)
    !dual_sar_mode |=> thr.hyst_near == $past(margin_ui_near_threshold))
    else $error("margin near threshold not unscaled");

  a_pad_a_near: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 1'b1 |-> thr.a_near == $past(sar_ant1_near_threshold))
    else $error("pad A near threshold not unscaled");

  a_pad_a_firm: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 1'b1 |-> thr.a_firm ==
      16'(({16'h0000, $past(sar_ant1_firm_contact_threshold)} * {8'h00, $past(long_term_baseline_a)}) >> 8))
    else $error("pad A firm contact scaling wrong");

  a_pad_b_contact: assert property (@(posedge mclk) disable iff (!rst_n)
    dual_sar_mode |=> thr.b_contact == $past(margin_ui_near_threshold))
    else $error("pad B contact threshold not unscaled");

  a_margin_b_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    !dual_sar_mode |=> thr.b_near == 8'h00 && thr.b_contact == 8'h00 && thr.b_firm == 10'h000)
    else $error("pad B view active in margin mode");

  a_settings_rsvd: assert property (@(posedge mclk) disable iff (!rst_n)
    (margin_ui_settings & thcb_pkg::SETTINGS_RSVD_MASK) ==
      (thcb_pkg::RST_SETTINGS & thcb_pkg::SETTINGS_RSVD_MASK))
    else $error("unused settings bits changed");

  a_dual_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_fire && dual_sar_mode && ptr == thcb_pkg::OFS_SETTINGS) |=> $stable(margin_ui_settings))
    else $error("settings written in dual-pad mode");

  c_write: cover property (@(posedge mclk) disable iff (!rst_n) wr_fire);
  c_read: cover property (@(posedge mclk) disable iff (!rst_n) state == thcb_pkg::ST_HOST_ACK && scl_rise);
  c_dual_write: cover property (@(posedge mclk) disable iff (!rst_n) wr_fire && dual_sar_mode);
  c_dual_read: cover property (@(posedge mclk) disable iff (!rst_n) state == thcb_pkg::ST_RDATA && dual_sar_mode);

endmodule // thcb_bank

`default_nettype wire

//--- verif/thcb_host.sv
// Host model driving the two-wire serial bus of the configuration bank.
// Assumes the data line is a wired-AND with a pull-up resolved by the bench.
`timescale 1ns/1ps
`default_nettype none

module thcb_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Phases of 5 mclk keep both SCL levels above the 8 mclk minimum
  localparam int PH = 5;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Also serves as repeated start: data released first, then clock raised
  task automatic start;
    tick(PH);
    sda_pull = 1'b0;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    sda_pull = 1'b1;
    tick(PH);
    scl = 1'b0;
  endtask

  task automatic stop;
    tick(PH);
    sda_pull = 1'b1;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    sda_pull = 1'b0;
    tick(2 * PH);
  endtask

  // Data changes mid-low, sampled mid-high, so the sync delay never overlaps
  task automatic bit_io(input logic b, output logic seen);
    tick(PH);
    sda_pull = ~b;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    seen = sda;
    tick(PH);
    scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule // thcb_host

`default_nettype wire

//--- verif/thcb_bank_test.sv
// Self-checking bench for the threshold configuration bank.
// Assumes the host model on the serial pins and the bench driving mode and baseline.
`timescale 1ns/1ps
`default_nettype none

module thcb_bank_test;
  logic                mclk;
  logic                rst_n;
  logic                dual;
  logic                scl;
  logic                host_pull;
  logic                sda_out;
  logic                sda_oe;
  wire logic           sda;
  logic [15:0]         long_term_baseline;
  logic [15:0]         rnd;
  logic [7:0]          s, h, n, t;
  logic [7:0]          q [4];
  logic [23:0]         p;
  thcb_pkg::thcb_thr_t thr;
  int                  fails, n_checks;

  // Pull-up: the line is low only while somebody pulls it
  assign sda = ~(host_pull | (sda_oe & ~sda_out));

  thcb_bank dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
                 .sda_oe(sda_oe), .dual_sar_mode(dual), .long_term_baseline_a(long_term_baseline), .thr(thr));
  thcb_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(host_pull));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] mgn(input logic [9:0] v, input logic [1:0] c, input logic touch);
    case (c)
      2'h0: return 16'h0000;
      2'h1: return 16'(v >> 3);
      2'h2: return touch ? 16'(v >> 2) : 16'(v >> 3);
      default: return 16'(v >> 4);
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    host.wbyte(d, a);
    chk("ack", {15'h0000, exp_ack}, {15'h0000, a});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v [4]);
    host.start();
    send({thcb_pkg::DEV_ADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
    foreach (v[i]) send(v[i], 1'b1);
    host.stop();
  endtask

  task automatic rd(input logic [7:0] a, input int cnt);
    logic [7:0] d;
    host.start();
    send({thcb_pkg::DEV_ADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
    host.start();
    send({thcb_pkg::DEV_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      host.rbyte(i == cnt - 1, d);
      q[i] = d;
    end
    host.stop();
  endtask

  task automatic chk_margin(input logic [7:0] sv, hv, nv, tv);
    chk("hyst_near", 16'(nv), 16'(thr.hyst_near));
    chk("hyst_contact", {6'h00, tv, 2'h0}, 16'(thr.hyst_contact));
    chk("near_margin", mgn(10'(nv), sv[1:0], 1'b0), 16'(thr.hyst_near_margin));
    chk("contact_margin", mgn({tv, 2'h0}, sv[5:4], 1'b1), 16'(thr.hyst_contact_margin));
    chk("halt_always", 16'(hv == 8'h00), 16'(thr.halt_always));
    if (hv != 8'h00) chk("halt_thr", 16'(hv), 16'(thr.halt_thr));
    chk("b_firm", 16'h0000, 16'(thr.b_firm));
  endtask

  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    dual = 1'b0;
    long_term_baseline = 16'h0000;
    rnd = 16'h0005;
    fails = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    host.tick(4);
    chk_margin(8'hA2, 8'h0A, 8'h16, 8'h25);
    chk("a_near", 16'h0000, 16'(thr.a_near));
    rd(8'h80, 4);
    chk("rd_80_81", {thcb_pkg::RST_SETTINGS, thcb_pkg::RST_81}, {q[0], q[1]});
    chk("rd_82_83", {thcb_pkg::RST_82, thcb_pkg::RST_83}, {q[2], q[3]});
    // All 16 code pairs, reserved bits random, halt corners at 0 and 254
    for (int c = 0; c < 16; c++) begin
      rnd = lfsr(rnd);
      s = (rnd[7:0] & 8'hCC) | {2'h0, 2'(c >> 2), 2'h0, 2'(c)};
      h = (c == 0) ? 8'h00 : (c == 1) ? 8'hFE : rnd[15:8];
      rnd = lfsr(rnd);
      n = rnd[7:0];
      t = (c == 15) ? 8'hFF : rnd[15:8];
      wr(8'h80, '{s, h, n, t});
      chk_margin(s, h, n, t);
      rd(8'h80, 1);
      chk("settings", 16'((thcb_pkg::RST_SETTINGS & 8'hCC) | (s & 8'h33)), 16'(q[0]));
    end
    // Pad A with baseline corners; 0x62 sits unmapped inside the burst
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      long_term_baseline = (k == 0) ? 16'hFFFF : rnd;
      rnd = lfsr(rnd);
      wr(8'h60, '{rnd[7:0], rnd[15:8], 8'h5A, ~rnd[7:0]});
      p = rnd[15:8] * long_term_baseline;
      chk("a_near", 16'(rnd[7:0]), 16'(thr.a_near));
      chk("a_contact", p[23:8], thr.a_contact);
      p = 8'(~rnd[7:0]) * long_term_baseline;
      chk("a_firm", p[23:8], thr.a_firm);
      @(posedge mclk);
      #1 long_term_baseline = ~long_term_baseline;
      host.tick(2);
      p = rnd[15:8] * long_term_baseline;
      chk("a_contact_lta", p[23:8], thr.a_contact);
      rd(8'h62, 1);
      chk("unmapped", 16'h0000, 16'(q[0]));
    end
    @(posedge mclk);
    #1 dual = 1'b1;
    host.tick(2);
    chk("b_near", 16'(h), 16'(thr.b_near));
    chk("b_contact", 16'(n), 16'(thr.b_contact));
    chk("b_firm", {6'h00, t, 2'h0}, 16'(thr.b_firm));
    chk("hyst_off", 16'h0000, 16'(thr.hyst_near_margin | thr.hyst_contact_margin));
    wr(8'h80, '{8'h33, 8'h00, 8'hFF, 8'h01});
    chk("b_near0", 16'h0000, 16'(thr.b_near));
    chk("b_contact_max", 16'h00FF, 16'(thr.b_contact));
    chk("b_firm4", 16'h0004, 16'(thr.b_firm));
    chk("halt_dual", 16'h0000, 16'(thr.halt_always));
    rd(8'h80, 1);
    chk("dual_settings", 16'h0000, 16'(q[0]));
    @(posedge mclk);
    #1 dual = 1'b0;
    host.tick(2);
    chk_margin(s, 8'h00, 8'hFF, 8'h01);
    // Reset in mid-run must bring back the reset values at 0x60, 0x61 and 0x80 to 0x83
    @(posedge mclk);
    #1 rst_n = 1'b0;
    host.tick(2);
    rst_n = 1'b1;
    host.tick(2);
    chk_margin(thcb_pkg::RST_SETTINGS, thcb_pkg::RST_81, thcb_pkg::RST_82, thcb_pkg::RST_83);
    chk("a_contact_rst", 16'h0000, thr.a_contact);
    chk("a_near_rst", 16'(thcb_pkg::RST_A_THR), 16'(thr.a_near));
    host.start();
    send({7'h2B, 1'b0}, 1'b0);
    host.stop();
    print_verdict();
  end
endmodule // thcb_bank_test

`default_nettype wire
